// [include/art_consts.svh]
// register map, field positions, reset values and tick counts for the reload timer
`ifndef ART_CONSTS_SVH
`define ART_CONSTS_SVH
`define ART_OFF_CTRL     8'h00
`define ART_OFF_CLKCTL   8'h04
`define ART_OFF_CNT_LO   8'h08
`define ART_OFF_CNT_HI   8'h0c
`define ART_OFF_RLD_LO   8'h10
`define ART_OFF_RLD_HI   8'h14
`define ART_OFF_GLB_EN   8'h18
`define ART_B_HI_OVF     7
`define ART_B_LO_OVF     6
`define ART_B_LO_IRQ_EN  5
`define ART_B_CAP_EN     4
`define ART_B_SPLIT      3
`define ART_B_RUN        2
`define ART_B_XCLK       0
`define ART_B_HI_FAST    5
`define ART_B_LO_FAST    4
`define ART_B_TMR_IRQ_EN 5
`define ART_RST_BYTE     8'h00
`define ART_CTRL_WMASK   8'hfd
`define ART_CLKCTL_WMASK 8'h3f
`define ART_BYTE_MAX     8'hff
`define ART_SYS_DIV_LAST 4'hb
`define ART_EXT_DIV_LAST 3'h7
`endif

// [include/art_pkg.sv]
// types shared by the reload timer and its bench
package art_pkg;
  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [3:0]  sel;
    logic [7:0]  adr;
    logic [31:0] dat;
  } art_wb_req_t;
endpackage

// [hdl/art_timer.sv]
// 16-bit or dual 8-bit auto-reload timer with capture, classic wishbone slave
`timescale 1ns/1ps
`include "art_consts.svh"

// Operation
// R01: count is two software-accessible bytes
// R02: ticks: sysclk, sysclk/12, external/8
// R03: external clock synchronised before counting
// R04: split clear gives one 16-bit counter
// R05: 16-bit overflow reloads, sets high flag
// R06: timer enable requests irq on overflow
// R07: low enable adds irq on low rollover
// R08: split set gives two 8-bit counters
// R09: each byte reloads from its reload byte
// R10: high byte gated by run bit
// R11: low byte always counts in split
// R12: per-byte clock select in split mode
// R13: each byte rollover sets its flag
// R14: split irq on high, or either byte
// R15: flags cleared only by software
// R16: software reads both flags to find cause
// R17: capture mode measures external clock
// R18: capture copies count to reload, sets flag
// R19: capture on falling edge of external/8
// R20: 16-bit counts only while run set
// R21: 16-bit uses the low byte clock select
module art_timer (
  input  wire logic                 clk_in,
  input  wire logic                 reset_n_in,
  input  wire art_pkg::art_wb_req_t wb_req_in,
  output logic [31:0]               wb_dat_out,
  output logic                      wb_ack_out,
  input  wire logic                 ext_osc_in,
  output logic                      timer_irq_out
);

  logic [7:0]  ctrl_reg;
  logic [7:0]  ctrl_next;
  logic [7:0]  clkctl_reg;
  logic [7:0]  clkctl_next;
  logic [7:0]  global_irq_enable_reg;
  logic [7:0]  global_irq_enable_next;
  logic [7:0]  cnt_lo_reg;
  logic [7:0]  cnt_lo_next;
  logic [7:0]  cnt_hi_reg;
  logic [7:0]  cnt_hi_next;
  logic [7:0]  rld_lo_reg;
  logic [7:0]  rld_lo_next;
  logic [7:0]  rld_hi_reg;
  logic [7:0]  rld_hi_next;
  logic        ack_reg;
  logic [31:0] rdat_reg;
  logic [31:0] rdat_next;
  logic [3:0]  div12_reg;
  logic [3:0]  div12_next;
  logic        ext_s1_reg;
  logic        ext_s2_reg;
  logic        ext_s3_reg;
  logic [2:0]  ext_div_reg;
  logic [2:0]  ext_div_next;

  // bus decode
  wire        access  = wb_req_in.cyc & wb_req_in.stb & ~ack_reg;
  wire        wr_lane = access & wb_req_in.we & wb_req_in.sel[0];
  wire [7:0]  wbyte   = wb_req_in.dat[7:0];

  function automatic logic wr_hit(input logic wr, input logic [7:0] a,
                                  input logic [7:0] off);
    return wr && (a == off);
  endfunction

  wire wr_ctrl   = wr_hit(wr_lane, wb_req_in.adr, `ART_OFF_CTRL);
  wire wr_clkctl = wr_hit(wr_lane, wb_req_in.adr, `ART_OFF_CLKCTL);
  wire wr_glb_en = wr_hit(wr_lane, wb_req_in.adr, `ART_OFF_GLB_EN);
  wire wr_lo     = wr_hit(wr_lane, wb_req_in.adr, `ART_OFF_CNT_LO);
  wire wr_hi     = wr_hit(wr_lane, wb_req_in.adr, `ART_OFF_CNT_HI);
  wire wr_rlo    = wr_hit(wr_lane, wb_req_in.adr, `ART_OFF_RLD_LO);
  wire wr_rhi    = wr_hit(wr_lane, wb_req_in.adr, `ART_OFF_RLD_HI);

  // unmapped addresses read zero and swallow writes
  wire [7:0] rd_byte =
    (wb_req_in.adr == `ART_OFF_CTRL)   ? ctrl_reg   :
    (wb_req_in.adr == `ART_OFF_CLKCTL) ? clkctl_reg :
    (wb_req_in.adr == `ART_OFF_GLB_EN) ? global_irq_enable_reg :
    (wb_req_in.adr == `ART_OFF_CNT_LO) ? cnt_lo_reg :
    (wb_req_in.adr == `ART_OFF_CNT_HI) ? cnt_hi_reg :
    (wb_req_in.adr == `ART_OFF_RLD_LO) ? rld_lo_reg :
    (wb_req_in.adr == `ART_OFF_RLD_HI) ? rld_hi_reg : `ART_RST_BYTE;
  assign rdat_next = access ? {24'h000000, rd_byte} : rdat_reg;

  // tick sources
  wire tick12 = (div12_reg == `ART_SYS_DIV_LAST);  // R02
  assign div12_next = tick12 ? 4'h0 : div12_reg + 4'h1;
  // only the second and third stages are looked at; the first may be metastable
  wire ext_rise = ext_s2_reg & ~ext_s3_reg;  // R03
  wire ext_wrap = ext_rise & (ext_div_reg == `ART_EXT_DIV_LAST);
  assign ext_div_next = ext_rise ? ext_div_reg + 3'h1 : ext_div_reg;
  // divided clock is ext_div_reg[2]; it falls exactly on the wrap
  wire tickx   = ext_wrap;  // R02
  wire cap_evt = ext_wrap & ctrl_reg[`ART_B_CAP_EN];  // R17 R19

  function automatic logic sel_tick(input logic fast, input logic xclk,
                                    input logic t12, input logic tx);
    return fast ? 1'b1 : (xclk ? tx : t12);
  endfunction

  wire split   = ctrl_reg[`ART_B_SPLIT];
  wire run     = ctrl_reg[`ART_B_RUN];
  wire xclk    = ctrl_reg[`ART_B_XCLK];
  wire lo_tick = sel_tick(clkctl_reg[`ART_B_LO_FAST], xclk, tick12, tickx);  // R12 R21
  wire hi_tick = sel_tick(clkctl_reg[`ART_B_HI_FAST], xclk, tick12, tickx);  // R12

  // counting
  wire lo_max  = (cnt_lo_reg == `ART_BYTE_MAX);
  wire hi_max  = (cnt_hi_reg == `ART_BYTE_MAX);
  wire lo_adv  = split ? lo_tick : (run & lo_tick);  // R11 R20 R21
  wire hi_adv  = split ? (run & hi_tick) : (run & lo_tick & lo_max);  // R04 R08 R10
  wire lo_wrap = lo_adv & lo_max;
  wire hi_wrap = hi_adv & hi_max;
  // in 16-bit mode the low byte only reloads on the full overflow
  wire lo_load = split ? lo_wrap : hi_wrap;  // R05 R09

  assign cnt_lo_next = wr_lo   ? wbyte :  // R01
                       lo_load ? rld_lo_reg :  // R09
                       lo_adv  ? cnt_lo_reg + 8'h01 : cnt_lo_reg;
  assign cnt_hi_next = wr_hi   ? wbyte :  // R01
                       hi_wrap ? rld_hi_reg :  // R05 R09
                       hi_adv  ? cnt_hi_reg + 8'h01 : cnt_hi_reg;

  // capture outranks a software write to the reload bytes
  assign rld_lo_next = cap_evt ? cnt_lo_reg : (wr_rlo ? wbyte : rld_lo_reg);  // R18
  assign rld_hi_next = cap_evt ? cnt_hi_reg : (wr_rhi ? wbyte : rld_hi_reg);  // R18

  // flags: a hardware set wins over a software clear in the same cycle
  wire       hi_set   = hi_wrap | cap_evt;  // R05 R13 R18
  wire       lo_set   = lo_wrap;  // R13
  wire [7:0] ctrl_wr  = wr_ctrl ? (wbyte & `ART_CTRL_WMASK) : ctrl_reg;  // R15
  assign ctrl_next   = ctrl_wr | {hi_set, lo_set, 6'h00};
  assign clkctl_next = wr_clkctl ? (wbyte & `ART_CLKCTL_WMASK) : clkctl_reg;
  assign global_irq_enable_next = wr_glb_en ? wbyte : global_irq_enable_reg;

  // level request; the servicing code checks both flags to find the cause
  assign timer_irq_out = global_irq_enable_reg[`ART_B_TMR_IRQ_EN] &
    (ctrl_reg[`ART_B_HI_OVF] |
     (ctrl_reg[`ART_B_LO_IRQ_EN] & ctrl_reg[`ART_B_LO_OVF]));  // R06 R07 R14

  assign wb_ack_out = ack_reg;
  assign wb_dat_out = rdat_reg;

  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      ack_reg  <= 1'b0;
      rdat_reg <= 32'h00000000;
    end else begin
      ack_reg  <= access;
      rdat_reg <= rdat_next;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      ctrl_reg   <= `ART_RST_BYTE;
      clkctl_reg <= `ART_RST_BYTE;
      global_irq_enable_reg <= `ART_RST_BYTE;
      cnt_lo_reg <= `ART_RST_BYTE;
      cnt_hi_reg <= `ART_RST_BYTE;
      rld_lo_reg <= `ART_RST_BYTE;
      rld_hi_reg <= `ART_RST_BYTE;
    end else begin
      ctrl_reg   <= ctrl_next;
      clkctl_reg <= clkctl_next;
      global_irq_enable_reg <= global_irq_enable_next;
      cnt_lo_reg <= cnt_lo_next;
      cnt_hi_reg <= cnt_hi_next;
      rld_lo_reg <= rld_lo_next;
      rld_hi_reg <= rld_hi_next;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      div12_reg   <= 4'h0;
      ext_s1_reg  <= 1'b0;
      ext_s2_reg  <= 1'b0;
      ext_s3_reg  <= 1'b0;
      ext_div_reg <= 3'h0;
    end else begin
      div12_reg   <= div12_next;
      ext_s1_reg  <= ext_osc_in;
      ext_s2_reg  <= ext_s1_reg;
      ext_s3_reg  <= ext_s2_reg;
      ext_div_reg <= ext_div_next;
    end
  end

  // checks
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!reset_n_in);

  sequence s_div_gap;
    (!tick12) [*8] ##1 (!tick12) [*3] ##1 tick12;
  endsequence

  a_div12_period: assert property (tick12 |=> s_div_gap)  // R02
    else $error("divide-by-12 tick period wrong");

  a_ext_sync_depth: assert property (  // R03
    ext_rise |-> $past(ext_osc_in, 2) && !$past(ext_osc_in, 3))
    else $error("external edge not two stages late");

  a_count_write: assert property (  // R01
    wr_lo |=> cnt_lo_reg == $past(wbyte))
    else $error("low count byte write lost");

  a_full_reload: assert property (  // R05
    (!split && run && lo_tick && lo_max && hi_max && !wr_lo && !wr_hi)
    |=> cnt_lo_reg == $past(rld_lo_reg) && cnt_hi_reg == $past(rld_hi_reg)
        && ctrl_reg[`ART_B_HI_OVF])
    else $error("16-bit overflow did not reload");

  a_hold_stopped: assert property (  // R20
    (!split && !run && !wr_lo && !wr_hi)
    |=> $stable(cnt_lo_reg) && $stable(cnt_hi_reg))
    else $error("stopped 16-bit counter moved");

  a_low_free_run: assert property (  // R11
    (split && lo_tick && !lo_max && !wr_lo) |=> cnt_lo_reg == $past(cnt_lo_reg) + 8'h01)
    else $error("split low byte did not count");

  a_high_gated: assert property (  // R10
    (split && !run && !wr_hi) |=> $stable(cnt_hi_reg))
    else $error("split high byte counted while stopped");

  a_split_reload: assert property (  // R09
    (split && lo_tick && lo_max && !wr_lo) |=> cnt_lo_reg == $past(rld_lo_reg)
    && ctrl_reg[`ART_B_LO_OVF])
    else $error("split low byte reload wrong");

  a_flag_sticky: assert property (  // R15
    (ctrl_reg[`ART_B_HI_OVF] && !wr_ctrl) |=> ctrl_reg[`ART_B_HI_OVF])
    else $error("high flag cleared by hardware");

  a_capture_copy: assert property (  // R18
    cap_evt |=> rld_hi_reg == $past(cnt_hi_reg) && rld_lo_reg == $past(cnt_lo_reg)
    && ctrl_reg[`ART_B_HI_OVF])
    else $error("capture did not copy count");

  a_irq_request: assert property (  // R06 R07 R14
    (global_irq_enable_reg[`ART_B_TMR_IRQ_EN] && !wr_glb_en &&
     (hi_set || (lo_set && ctrl_reg[`ART_B_LO_IRQ_EN] && !wr_ctrl)))
    |=> timer_irq_out)
    else $error("interrupt request missing");

  a_ack_single: assert property (access |=> wb_ack_out ##1 !wb_ack_out)
    else $error("bus ack not one cycle");

  a_div12_range: assert property (div12_reg <= `ART_SYS_DIV_LAST)  // R02
    else $error("divide-by-12 counter out of range");

  a_ext_div_step: assert property (  // R02
    ext_rise |=> ext_div_reg == $past(ext_div_reg) + 3'h1)
    else $error("external divider missed an edge");

  a_ext_div_idle: assert property (  // R02
    !ext_rise |=> $stable(ext_div_reg))
    else $error("external divider moved without an edge");

  a_capture_edge: assert property (cap_evt |=> $fell(ext_div_reg[2]))  // R19
    else $error("capture not on falling divided clock");

  a_no_capture: assert property (  // R17 R18
    (!cap_evt && !wr_rlo && !wr_rhi) |=> $stable(rld_lo_reg) && $stable(rld_hi_reg))
    else $error("reload bytes changed without cause");

  a_high_write: assert property (  // R01
    wr_hi |=> cnt_hi_reg == $past(wbyte))
    else $error("high count byte write lost");

  a_carry_16: assert property (  // R04
    (!split && run && lo_tick && lo_max && !hi_max && !wr_lo && !wr_hi)
    |=> cnt_lo_reg == 8'h00 && cnt_hi_reg == $past(cnt_hi_reg) + 8'h01)
    else $error("16-bit carry into high byte wrong");

  a_count_16: assert property (  // R20
    (!split && run && lo_tick && !lo_max && !wr_lo && !wr_hi)
    |=> cnt_lo_reg == $past(cnt_lo_reg) + 8'h01 && $stable(cnt_hi_reg))
    else $error("16-bit counter did not advance");

  a_tick_16: assert property (  // R21
    (!split && !lo_tick && !wr_lo && !wr_hi)
    |=> $stable(cnt_lo_reg) && $stable(cnt_hi_reg))
    else $error("16-bit counter moved without a low-byte tick");

  a_low_flag_16: assert property (  // R07
    (!split && run && lo_tick && lo_max) |=> ctrl_reg[`ART_B_LO_OVF])
    else $error("low rollover flag missing in 16-bit mode");

  a_split_high_count: assert property (  // R08 R10
    (split && run && hi_tick && !hi_max && !wr_hi)
    |=> cnt_hi_reg == $past(cnt_hi_reg) + 8'h01)
    else $error("split high byte did not count");

  a_split_high_reload: assert property (  // R09 R13
    (split && run && hi_tick && hi_max && !wr_hi)
    |=> cnt_hi_reg == $past(rld_hi_reg) && ctrl_reg[`ART_B_HI_OVF])
    else $error("split high byte reload wrong");

  a_split_low_hold: assert property (  // R12
    (split && !lo_tick && !wr_lo) |=> $stable(cnt_lo_reg))
    else $error("split low byte moved without its tick");

  a_split_high_hold: assert property (  // R12
    (split && !hi_tick && !wr_hi) |=> $stable(cnt_hi_reg))
    else $error("split high byte moved without its tick");

  a_ext_tick_count: assert property (  // R02 R12
    (split && xclk && !clkctl_reg[`ART_B_LO_FAST] && ext_wrap && !lo_max && !wr_lo)
    |=> cnt_lo_reg == $past(cnt_lo_reg) + 8'h01)
    else $error("external tick did not advance low byte");

  a_slow_tick_count: assert property (  // R02 R12
    (split && !xclk && !clkctl_reg[`ART_B_LO_FAST] && tick12 && !lo_max && !wr_lo)
    |=> cnt_lo_reg == $past(cnt_lo_reg) + 8'h01)
    else $error("divided tick did not advance low byte");

  a_low_flag_sticky: assert property (  // R15
    (ctrl_reg[`ART_B_LO_OVF] && !wr_ctrl) |=> ctrl_reg[`ART_B_LO_OVF])
    else $error("low flag cleared by hardware");

  a_flag_set_wins: assert property (  // R15
    (wr_ctrl && hi_set) |=> ctrl_reg[`ART_B_HI_OVF])
    else $error("software clear beat a hardware set");

  a_irq_quiet: assert property (  // R06 R14
    (!global_irq_enable_reg[`ART_B_TMR_IRQ_EN] || (!ctrl_reg[`ART_B_HI_OVF] &&
     !(ctrl_reg[`ART_B_LO_IRQ_EN] && ctrl_reg[`ART_B_LO_OVF]))) |-> !timer_irq_out)
    else $error("interrupt request without cause");

  a_reserved_zero: assert property (  // R01
    !ctrl_reg[1] && clkctl_reg[7:6] == 2'h0)
    else $error("reserved control bits not zero");

  a_lane_ignored: assert property (  // R01
    (access && wb_req_in.we && !wb_req_in.sel[0]) |=> $stable(global_irq_enable_reg))
    else $error("write without byte lane took effect");

  a_read_upper: assert property (wb_ack_out |-> wb_dat_out[31:8] == 24'h000000)
    else $error("read data upper bits not zero");

endmodule

// [tb/test_art_timer.sv]
// self-checking bench for the reload timer
`timescale 1ns/1ps
`include "art_consts.svh"
module test_art_timer;
  logic                 clk_in;
  logic                 reset_n_in;
  art_pkg::art_wb_req_t wb_req_in;
  logic [31:0]          wb_dat_out;
  logic                 wb_ack_out;
  logic                 ext_osc_in;
  logic                 timer_irq_out;
  int                   n_mismatch;
  int                   comparisons;
  logic [7:0]           q;
  logic [7:0]           q2;

  art_timer art_timer_i (.clk_in(clk_in), .reset_n_in(reset_n_in), .wb_req_in(wb_req_in),
    .wb_dat_out(wb_dat_out), .wb_ack_out(wb_ack_out), .ext_osc_in(ext_osc_in),
    .timer_irq_out(timer_irq_out));

  initial begin
    clk_in = 1'b0;
    forever #2.5 clk_in = ~clk_in;
  end

  task automatic chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // classic cycle; waits for ack, then idles one cycle before the next request
  task automatic bus(input logic [7:0] a, input logic w, input logic [7:0] d);
    wb_req_in <= '{cyc: 1'b1, stb: 1'b1, we: w, sel: 4'h1, adr: a, dat: {24'h0, d}};
    do begin
      @(posedge clk_in);
    end while (wb_ack_out !== 1'b1);
    q = wb_dat_out[7:0];
    wb_req_in <= '0;
    @(posedge clk_in);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus(a, 1'b1, d);
  endtask

  task automatic rd(input logic [7:0] a);
    bus(a, 1'b0, 8'h00);
  endtask

  task automatic t_reset_map;
    rd(`ART_OFF_CTRL);   chk("ctrl_rst", q, 8'h00);
    rd(`ART_OFF_CLKCTL); chk("clkctl_rst", q, 8'h00);
    rd(8'h1c);           chk("unmapped", q, 8'h00);
    wr(`ART_OFF_CNT_HI, 8'h5a);
    rd(`ART_OFF_CNT_HI); chk("cnt_hi_rw", q, 8'h5a);
  endtask

  task automatic t_sixteen;
    wr(`ART_OFF_CLKCTL, 8'h10);
    wr(`ART_OFF_CNT_LO, 8'hfe);
    wr(`ART_OFF_CNT_HI, 8'hff);
    wr(`ART_OFF_RLD_LO, 8'hcd);
    wr(`ART_OFF_RLD_HI, 8'hab);
    wr(`ART_OFF_GLB_EN, 8'h20);
    wr(`ART_OFF_CTRL, 8'h04);
    repeat (10) @(posedge clk_in);
    chk("irq16", {7'h0, timer_irq_out}, 8'h01);
    rd(`ART_OFF_CTRL);   chk("hi_flag16", {7'h0, q[7]}, 8'h01);
    wr(`ART_OFF_CTRL, 8'h00);
    rd(`ART_OFF_CNT_HI); chk("reload16", q, 8'hab);
    rd(`ART_OFF_CNT_LO);
    q2 = q;
    repeat (20) @(posedge clk_in);
    rd(`ART_OFF_CNT_LO); chk("hold16", q, q2);
    chk("irq_clr", {7'h0, timer_irq_out}, 8'h00);
    wr(`ART_OFF_CNT_LO, 8'hfe);
    wr(`ART_OFF_CNT_HI, 8'h00);
    wr(`ART_OFF_CTRL, 8'h24);
    repeat (10) @(posedge clk_in);
    chk("irq_lo16", {7'h0, timer_irq_out}, 8'h01);
    rd(`ART_OFF_CTRL);   chk("no_hi16", {7'h0, q[7]}, 8'h00);
    rd(`ART_OFF_CNT_HI); chk("carry16", q, 8'h01);
  endtask

  task automatic t_split;
    wr(`ART_OFF_CTRL, 8'h00);
    wr(`ART_OFF_CLKCTL, 8'h30);
    wr(`ART_OFF_RLD_LO, 8'h10);
    wr(`ART_OFF_CNT_LO, 8'hfe);
    wr(`ART_OFF_CNT_HI, 8'h55);
    wr(`ART_OFF_CTRL, 8'h08);
    repeat (10) @(posedge clk_in);
    rd(`ART_OFF_CNT_HI); chk("hi_gated", q, 8'h55);
    rd(`ART_OFF_CTRL);   chk("lo_flag", q, 8'h48);
    chk("irq_hi_only", {7'h0, timer_irq_out}, 8'h00);
    rd(`ART_OFF_CNT_LO); chk("lo_reload", {7'h0, q >= 8'h10 && q < 8'h40}, 8'h01);
    repeat (300) @(posedge clk_in);
    rd(`ART_OFF_CTRL);   chk("flag_kept", q, 8'h48);
    wr(`ART_OFF_CTRL, 8'h28);
    repeat (300) @(posedge clk_in);
    chk("irq_lo", {7'h0, timer_irq_out}, 8'h01);
    wr(`ART_OFF_CNT_HI, 8'hfe);
    wr(`ART_OFF_CTRL, 8'h0c);
    repeat (10) @(posedge clk_in);
    rd(`ART_OFF_CTRL);   chk("hi_flag8", {7'h0, q[7]}, 8'h01);
  endtask

  // slow external clock: sixteen rising edges give exactly two divided ticks
  task automatic t_ext;
    wr(`ART_OFF_CTRL, 8'h00);
    wr(`ART_OFF_CLKCTL, 8'h00);
    wr(`ART_OFF_CNT_LO, 8'h20);
    wr(`ART_OFF_CNT_HI, 8'h77);
    wr(`ART_OFF_CTRL, 8'h19);
    repeat (16) begin
      ext_osc_in <= 1'b1;
      repeat (4) @(posedge clk_in);
      ext_osc_in <= 1'b0;
      repeat (4) @(posedge clk_in);
    end
    repeat (6) @(posedge clk_in);
    rd(`ART_OFF_CNT_LO); chk("ext_div8", q, 8'h22);
    rd(`ART_OFF_RLD_HI); chk("capture", q, 8'h77);
    rd(`ART_OFF_CTRL);   chk("cap_flag", {7'h0, q[7]}, 8'h01);
    wr(`ART_OFF_CTRL, 8'h0c);
    wr(`ART_OFF_CNT_LO, 8'h00);
    wr(`ART_OFF_CNT_HI, 8'h00);
    repeat (120) @(posedge clk_in);
    rd(`ART_OFF_CNT_LO); chk("div12", {7'h0, q >= 8'h09 && q <= 8'h0c}, 8'h01);
    rd(`ART_OFF_CNT_HI); chk("div12_hi", {7'h0, q >= 8'h09 && q <= 8'h0c}, 8'h01);
  endtask

  task automatic conclude;
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk_in);
    n_mismatch++;
    conclude;
  end

  initial begin
    n_mismatch = 0;
    comparisons = 0;
    reset_n_in <= 1'b0;
    wb_req_in <= '0;
    ext_osc_in <= 1'b0;
    repeat (10) @(posedge clk_in);
    reset_n_in <= 1'b1;
    @(posedge clk_in);
    t_reset_map;
    t_sixteen;
    t_split;
    t_ext;
    conclude;
  end
endmodule
